// >>> verilog/io_ports_pkg.sv
package io_ports_pkg;

  // Register offsets on the special-function-register port.
  localparam logic [7:0] ADDR_INPUT_PORT_LEVEL = 8'h00;
  localparam logic [7:0] ADDR_THIRD_PORT_DATA = 8'h01;
  localparam logic [7:0] ADDR_FOURTH_PORT_DATA = 8'h02;
  localparam logic [7:0] ADDR_SECOND_PORT_DATA = 8'h03;
  localparam logic [7:0] ADDR_OUTPUT_PORT_DATA = 8'h04;
  localparam logic [7:0] ADDR_SHARED_PORT_CONTROL = 8'h05;
  // Bit control registers: one per bidirectional pin, second port first.
  localparam logic [7:0] ADDR_BIT_CONTROL_BASE = 8'h10;
  localparam int NUM_BIDIR_BITS = 12;

  // Shared port control fields.
  localparam int INPUT_TERM_SELECT_BIT = 0;
  localparam int OUTPUT_DRIVE_SELECT_BIT = 1;
  localparam int PULL_SELECT_BIT = 2;

  // Per-bit control fields.
  localparam int BIT_MODE_POS = 0;
  localparam int BIT_DIR_POS = 1;
  localparam int BIT_SAMPLE_POS = 2;
  localparam int BIT_IRQ_EN_POS = 3;

  // Values after reset.
  localparam logic [3:0] PORT_DATA_RESET = 4'h0;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [3:0] READ_AS_ZERO = 4'h0;

  // Vector of the input-port level-change interrupt.
  localparam logic [11:0] LEVEL_CHANGE_VECTOR = 12'h032;

  // Sampling period of the time base, and the worst-case flag delay in cycles.
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_PERIOD_US = 15_625;
  localparam int SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
    logic [3:0] pull_up;
    logic [3:0] pull_down;
  } pad_ctrl_t;

endpackage : io_ports_pkg

// >>> verilog/four_bit_io_ports.sv
`timescale 1ns/1ns
// Functional notes
// - Input-only port is four bits; reading it returns the pin levels.
// - Input terminate bit: 0 resistor input, 1 high-impedance; all pins; resets 0.
// - Pull select: 0 pull-up, 1 pull-down; shared by all resistor inputs; resets 0.
// - Output drive bit: 0 push-pull, 1 open-drain, all four pins; resets 0.
// - Shared control register is write-only; software must not read-modify-write it.
// - Output port data register drives the pins and resets to zero.
// - Pins change after the write strobe, ending the writing instruction.
// - Read data is captured on the read strobe of the final cycle.
// - Input-port interrupt is evaluated on each falling edge of the 64 Hz tick.
// - Request flag sets within one 64 Hz period after a pin change.
// - Flag sets on level change of the combined pins; software reads port.
// - Pull-down: fire when all fall low, or any rises from all low.
// - Pull-up: fire when any falls from all high, or all rise high.
// - Level-change interrupt vectors to address 032H.
// - Each bidirectional bit configures resistor, high-Z, push-pull or open-drain.
// - Output-direction bit drives its data register bit onto the pin.
// - Bidirectional read returns latch for output bits, pin level for inputs.
// - Third port data register behaves the same as other bidirectional ports.
// - Bidirectional pins can request an interrupt on level change.
// - All bidirectional data registers clear to zero at reset.
// - Bit control: direction 0 input, mode 0 resistor/push-pull; reset zero.
module four_bit_io_ports
  import io_ports_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Special-function-register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_wdata_i,
  input wire logic sfr_we_i,
  input wire logic sfr_re_i,
  output logic [3:0] sfr_rdata_o,
  // Time base 64 Hz output
  input wire logic tb64_i,
  // Interrupt requests
  input wire logic level_change_clear_i,
  input wire logic bidir_change_clear_i,
  output logic level_change_request_flag_o,
  output logic bidir_change_request_flag_o,
  output logic [11:0] level_change_vector_o,
  // Input-only port pins
  input wire logic [3:0] input_pin_i,
  output logic [3:0] input_pull_up_o,
  output logic [3:0] input_pull_down_o,
  // Output-only port pins
  output logic [3:0] output_pin_o,
  output logic [3:0] output_pin_oe_o,
  // Bidirectional pins: second, third and fourth ports, four bits each
  input wire logic [NUM_BIDIR_BITS-1:0] bidir_pin_i,
  output logic [NUM_BIDIR_BITS-1:0] bidir_pin_o,
  output logic [NUM_BIDIR_BITS-1:0] bidir_pin_oe_o,
  output logic [NUM_BIDIR_BITS-1:0] bidir_pull_up_o,
  output logic [NUM_BIDIR_BITS-1:0] bidir_pull_down_o
);

  function automatic logic [3:0] bidir_read(input logic [3:0] latch, input logic [3:0] pin,
                                            input logic [3:0] dir);
    bidir_read = (latch & dir) | (pin & ~dir);
  endfunction : bidir_read

  logic [3:0] input_meta;
  logic [3:0] input_sync;
  logic [NUM_BIDIR_BITS-1:0] bidir_meta;
  logic [NUM_BIDIR_BITS-1:0] bidir_sync;
  logic [NUM_BIDIR_BITS-1:0] bidir_prev;
  logic tb64_prev;
  logic combined_prev;
  logic [3:0] shared_port_control;
  logic [3:0] output_port_data;
  logic [NUM_BIDIR_BITS-1:0] bidir_data;
  logic [3:0] bit_control [NUM_BIDIR_BITS];

  // Bit-wise views of the per-bit control registers.
  logic [NUM_BIDIR_BITS-1:0] bit_direction;
  logic [NUM_BIDIR_BITS-1:0] bit_input_output_mode;
  logic [NUM_BIDIR_BITS-1:0] bit_sample_fast;
  logic [NUM_BIDIR_BITS-1:0] bit_irq_enable;
  always_comb
  begin
    for (int i = 0; i < NUM_BIDIR_BITS; i++)
    begin
      bit_direction[i] = bit_control[i][BIT_DIR_POS];
      bit_input_output_mode[i] = bit_control[i][BIT_MODE_POS];
      bit_sample_fast[i] = bit_control[i][BIT_SAMPLE_POS];
      bit_irq_enable[i] = bit_control[i][BIT_IRQ_EN_POS];
    end
  end

  wire input_term_select = shared_port_control[INPUT_TERM_SELECT_BIT];
  wire output_drive_select = shared_port_control[OUTPUT_DRIVE_SELECT_BIT];
  wire pull_select = shared_port_control[PULL_SELECT_BIT];

  // Address decode.
  wire wr_output = sfr_we_i && (sfr_addr_i == ADDR_OUTPUT_PORT_DATA);
  wire wr_shared = sfr_we_i && (sfr_addr_i == ADDR_SHARED_PORT_CONTROL);
  wire wr_second = sfr_we_i && (sfr_addr_i == ADDR_SECOND_PORT_DATA);
  wire wr_third = sfr_we_i && (sfr_addr_i == ADDR_THIRD_PORT_DATA);
  wire wr_fourth = sfr_we_i && (sfr_addr_i == ADDR_FOURTH_PORT_DATA);
  wire [7:0] ctrl_index = sfr_addr_i - ADDR_BIT_CONTROL_BASE;
  wire wr_ctrl = sfr_we_i && (sfr_addr_i >= ADDR_BIT_CONTROL_BASE)
                 && (ctrl_index < 8'(NUM_BIDIR_BITS));

  // Read mux; the shared control register has no read path.
  logic [3:0] read_value;
  always_comb
  begin
    if (sfr_addr_i == ADDR_INPUT_PORT_LEVEL)
      read_value = input_sync;
    else if (sfr_addr_i == ADDR_OUTPUT_PORT_DATA)
      read_value = output_port_data;
    else if (sfr_addr_i == ADDR_SECOND_PORT_DATA)
      read_value = bidir_read(bidir_data[3:0], bidir_sync[3:0], bit_direction[3:0]);
    else if (sfr_addr_i == ADDR_THIRD_PORT_DATA)
      read_value = bidir_read(bidir_data[7:4], bidir_sync[7:4], bit_direction[7:4]);
    else if (sfr_addr_i == ADDR_FOURTH_PORT_DATA)
      read_value = bidir_read(bidir_data[11:8], bidir_sync[11:8], bit_direction[11:8]);
    else
      read_value = READ_AS_ZERO;
  end

  // Level-change detection on the input-only port. Pull-up watches the AND of
  // the pins, pull-down the OR, so a single pin held away from its pull level masks the others.
  wire combined_level = pull_select ? |input_sync : &input_sync;
  wire sample_tick = tb64_prev && !tb64_i;
  wire level_event = sample_tick && (combined_level != combined_prev);

  // Bidirectional level change: 64 Hz sampling or every system clock per bit.
  logic [NUM_BIDIR_BITS-1:0] bidir_sample_en;
  always_comb
  begin
    for (int i = 0; i < NUM_BIDIR_BITS; i++)
      bidir_sample_en[i] = bit_sample_fast[i] || sample_tick;
  end
  wire bidir_event = |(bidir_sample_en & bit_irq_enable & (bidir_sync ^ bidir_prev));

  // Pad controls computed ahead of the output flops.
  pad_ctrl_t next_input_pad;
  pad_ctrl_t next_output_pad;
  logic [NUM_BIDIR_BITS-1:0] next_bidir_o;
  logic [NUM_BIDIR_BITS-1:0] next_bidir_oe;
  logic [NUM_BIDIR_BITS-1:0] next_bidir_pu;
  logic [NUM_BIDIR_BITS-1:0] next_bidir_pd;
  always_comb
  begin
    next_input_pad.o = 4'h0;
    next_input_pad.oe = 4'h0;
    next_input_pad.pull_up = {4{!input_term_select && !pull_select}};
    next_input_pad.pull_down = {4{!input_term_select && pull_select}};
    // Open-drain only ever sinks, so the pad is released for a one.
    next_output_pad.o = output_drive_select ? 4'h0 : output_port_data;
    next_output_pad.oe = output_drive_select ? ~output_port_data : 4'hf;
    next_output_pad.pull_up = 4'h0;
    next_output_pad.pull_down = 4'h0;
    for (int i = 0; i < NUM_BIDIR_BITS; i++)
    begin
      next_bidir_o[i] = bit_direction[i] && !bit_input_output_mode[i] && bidir_data[i];
      next_bidir_oe[i] = bit_direction[i]
                         && (!bit_input_output_mode[i] || !bidir_data[i]);
      next_bidir_pu[i] = !bit_direction[i] && !bit_input_output_mode[i] && !pull_select;
      next_bidir_pd[i] = !bit_direction[i] && !bit_input_output_mode[i] && pull_select;
    end
  end

  // Pins are synchronised; only the second stage is ever read.
  always_ff @(posedge clk_i)
  begin
    input_meta <= input_pin_i;
    input_sync <= input_meta;
    bidir_meta <= bidir_pin_i;
    bidir_sync <= bidir_meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tb64_prev <= 1'b0;
      combined_prev <= 1'b0;
      bidir_prev <= '0;
    end
    else
    begin
      tb64_prev <= tb64_i;
      if (sample_tick)
        combined_prev <= combined_level;
      for (int i = 0; i < NUM_BIDIR_BITS; i++)
        if (bidir_sample_en[i])
          bidir_prev[i] <= bidir_sync[i];
    end
  end

  // Shared control and output data. The control register has no read path, so
  // software must keep its own copy of it.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      shared_port_control <= CONTROL_RESET;
      output_port_data <= PORT_DATA_RESET;
    end
    else
    begin
      if (wr_shared)
        shared_port_control <= sfr_wdata_i;
      if (wr_output)
        output_port_data <= sfr_wdata_i;
    end
  end

  // Bidirectional data latches, one nibble per port.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      bidir_data <= '0;
    else
    begin
      if (wr_second)
        bidir_data[3:0] <= sfr_wdata_i;
      if (wr_third)
        bidir_data[7:4] <= sfr_wdata_i;
      if (wr_fourth)
        bidir_data[11:8] <= sfr_wdata_i;
    end
  end

  // Per-bit control registers.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NUM_BIDIR_BITS; i++)
        bit_control[i] <= CONTROL_RESET;
    end
    else if (wr_ctrl)
      bit_control[ctrl_index[3:0]] <= sfr_wdata_i;
  end

  // Setting wins over a clear in the same cycle, so no change between clears is lost.
  function automatic logic next_flag(input logic flag, input logic set, input logic clear);
    next_flag = set || (flag && !clear);
  endfunction : next_flag

  // Read data is captured on the read strobe and then stands until the next one.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      sfr_rdata_o <= READ_AS_ZERO;
    else if (sfr_re_i)
      sfr_rdata_o <= read_value;
  end

  // Request flags and the fixed vector.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      level_change_request_flag_o <= 1'b0;
      bidir_change_request_flag_o <= 1'b0;
      level_change_vector_o <= LEVEL_CHANGE_VECTOR;
    end
    else
    begin
      level_change_request_flag_o <= next_flag(level_change_request_flag_o, level_event,
                                               level_change_clear_i);
      bidir_change_request_flag_o <= next_flag(bidir_change_request_flag_o, bidir_event,
                                               bidir_change_clear_i);
      level_change_vector_o <= LEVEL_CHANGE_VECTOR;
    end
  end

  // Pull enables of the input-only port.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      input_pull_up_o <= '0;
      input_pull_down_o <= '0;
    end
    else
    begin
      input_pull_up_o <= next_input_pad.pull_up;
      input_pull_down_o <= next_input_pad.pull_down;
    end
  end

  // Output-only pads. A write reaches the pins one edge after the register,
  // which stands in for the late state of the write cycle.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      output_pin_o <= '0;
      output_pin_oe_o <= '0;
    end
    else
    begin
      output_pin_o <= next_output_pad.o;
      output_pin_oe_o <= next_output_pad.oe;
    end
  end

  // Bidirectional pads.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      bidir_pin_o <= '0;
      bidir_pin_oe_o <= '0;
      bidir_pull_up_o <= '0;
      bidir_pull_down_o <= '0;
    end
    else
    begin
      bidir_pin_o <= next_bidir_o;
      bidir_pin_oe_o <= next_bidir_oe;
      bidir_pull_up_o <= next_bidir_pu;
      bidir_pull_down_o <= next_bidir_pd;
    end
  end

endmodule : four_bit_io_ports

// >>> tb/four_bit_io_ports_assertions.sv
`timescale 1ns/1ns
module io_ports_checker
  import io_ports_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_wdata_i,
  input wire logic sfr_we_i,
  input wire logic sfr_re_i,
  input wire logic [3:0] sfr_rdata_o,
  // Interrupt and pins
  input wire logic tb64_i,
  input wire logic level_change_clear_i,
  input wire logic level_change_request_flag_o,
  input wire logic [11:0] level_change_vector_o,
  input wire logic [3:0] input_pin_i,
  input wire logic [3:0] output_pin_o,
  input wire logic [3:0] output_pin_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  wire out_wr = sfr_we_i && sfr_addr_i == ADDR_OUTPUT_PORT_DATA;
  wire in_rd = sfr_re_i && sfr_addr_i == ADDR_INPUT_PORT_LEVEL;
  a_vector_fixed: assert property (!$past(srst_i) |-> level_change_vector_o == 12'h032)
    else $error("vector wrong");
  a_flag_sticky: assert property (level_change_request_flag_o && !level_change_clear_i
    |=> level_change_request_flag_o) else $error("flag dropped");
  a_flag_on_tick: assert property ($rose(level_change_request_flag_o)
    |-> $past(tb64_i, 2) && !$past(tb64_i)) else $error("flag off tick");
  a_output_write: assert property (out_wr
    |-> ##2 (output_pin_o | ~output_pin_oe_o) == $past(sfr_wdata_i, 2)) else $error("pin late");
  a_drive_mode: assert property (output_pin_oe_o == 4'hf || output_pin_o == 4'h0)
    else $error("drive mode");
  a_control_reads_zero: assert property (sfr_re_i && sfr_addr_i == ADDR_SHARED_PORT_CONTROL
    |=> sfr_rdata_o == READ_AS_ZERO) else $error("control readable");
  a_rdata_holds: assert property (!sfr_re_i |=> $stable(sfr_rdata_o))
    else $error("read data moved");
  a_input_level: assert property (in_rd && !$past(srst_i) && !$past(srst_i, 2)
    && $stable(input_pin_i) && input_pin_i == $past(input_pin_i, 2)
    |=> sfr_rdata_o == $past(input_pin_i)) else $error("input level");
  c_flag: cover property ($rose(level_change_request_flag_o));
  c_write: cover property (out_wr);
  c_read: cover property (in_rd);
endmodule : io_ports_checker
bind four_bit_io_ports io_ports_checker io_ports_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o), .tb64_i(tb64_i),
  .level_change_clear_i(level_change_clear_i),
  .level_change_request_flag_o(level_change_request_flag_o),
  .level_change_vector_o(level_change_vector_o), .input_pin_i(input_pin_i),
  .output_pin_o(output_pin_o), .output_pin_oe_o(output_pin_oe_o)
);

// >>> tb/pin_equipment.sv
`timescale 1ns/1ns
module pin_equipment (
  // Clock and far-side drivers
  input wire logic clk_i,
  input wire logic [11:0] ext_en_i,
  input wire logic [11:0] ext_val_i,
  // Pad controls of the device
  input wire logic [11:0] dev_o_i,
  input wire logic [11:0] dev_oe_i,
  input wire logic [11:0] pu_i,
  input wire logic [11:0] pd_i,
  output logic [11:0] pin_o
);
  logic [11:0] float_q = 12'h000;
  // A pin nobody drives or pulls wanders, so a read of it is never trusted.
  always @(posedge clk_i) float_q <= ~float_q;
  always_comb
    for (int b = 0; b < 12; b++)
      pin_o[b] = dev_oe_i[b] ? dev_o_i[b] : ext_en_i[b] ? ext_val_i[b] :
        pu_i[b] ? 1'b1 : pd_i[b] ? 1'b0 : float_q[b];
endmodule : pin_equipment

// >>> tb/four_bit_io_ports_test.sv
`timescale 1ns/1ns
module four_bit_io_ports_test;
  import io_ports_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [3:0] wdata = 4'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic tb64 = 1'b0;
  logic clr = 1'b0;
  logic bclr = 1'b0;
  logic bflag;
  logic [11:0] vec;
  logic [3:0] ipu, ipd;
  logic [3:0] in_pin = 4'hf;
  logic [11:0] ext_en = 12'h000;
  logic [11:0] ext_val = 12'h000;
  logic [3:0] rdata, out_pin, out_oe;
  logic flag;
  logic [11:0] bpin_i, bpin_o, bpin_oe, bpu, bpd;
  logic [3:0] lvl_a [4] = '{4'hf, 4'he, 4'h0, 4'h4};
  logic [3:0] lvl_b [4] = '{4'he, 4'h0, 4'h4, 4'hf};
  int errors = 0;
  int checked = 0;
  always #50 clk_i = ~clk_i;
  four_bit_io_ports four_bit_io_ports_inst (
    .clk_i(clk_i), .srst_i(srst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_we_i(we), .sfr_re_i(re), .sfr_rdata_o(rdata), .tb64_i(tb64),
    .level_change_clear_i(clr), .bidir_change_clear_i(bclr),
    .level_change_request_flag_o(flag), .bidir_change_request_flag_o(bflag),
    .level_change_vector_o(vec), .input_pin_i(in_pin), .input_pull_up_o(ipu),
    .input_pull_down_o(ipd), .output_pin_o(out_pin), .output_pin_oe_o(out_oe),
    .bidir_pin_i(bpin_i), .bidir_pin_o(bpin_o), .bidir_pin_oe_o(bpin_oe),
    .bidir_pull_up_o(bpu), .bidir_pull_down_o(bpd)
  );
  pin_equipment pin_equipment_inst (
    .clk_i(clk_i), .ext_en_i(ext_en), .ext_val_i(ext_val), .dev_o_i(bpin_o),
    .dev_oe_i(bpin_oe), .pu_i(bpu), .pd_i(bpd), .pin_o(bpin_i)
  );
  function automatic logic fires(input logic pd, input logic [3:0] a, input logic [3:0] b);
    return pd ? ((|a) != (|b)) : ((&a) != (&b));
  endfunction : fires
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    step(1);
    we = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    addr = a;
    re = 1'b1;
    step(1);
    re = 1'b0;
    d = rdata;
    step(1);
  endtask : rd
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      errors++;
    end
  endtask : chk
  task automatic tick();
    tb64 = 1'b1;
    step(1);
    tb64 = 1'b0;
    step(2);
  endtask : tick
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    #5_000_000;
    errors++;
    wrap_up();
  end
  initial
  begin
    logic [3:0] v, d, dir, pins;
    void'($urandom(32'h00f1_e527));
    step(16);
    srst_i = 1'b0;
    step(3);
    rd(ADDR_OUTPUT_PORT_DATA, v);
    chk("output data", 12'h000, 12'(v));
    chk("output pads", 12'h0f0, {4'h0, out_oe, out_pin});
    chk("input pulls", 12'h00f, {4'h0, ipd, ipu});
    chk("vector", 12'h032, vec);
    rd(ADDR_THIRD_PORT_DATA, v);
    chk("third port", 12'h00f, 12'(v));
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 4'h0 : (i == 7) ? 4'hf : 4'($urandom);
      in_pin = 4'($urandom);
      wr(ADDR_SHARED_PORT_CONTROL, {2'b00, i[0], 1'b0});
      wr(ADDR_OUTPUT_PORT_DATA, d);
      step(1);
      chk("output pads", i[0] ? {4'h0, ~d, 4'h0} : {4'h0, 4'hf, d}, {4'h0, out_oe, out_pin});
      rd(ADDR_OUTPUT_PORT_DATA, v);
      chk("output data", 12'(d), 12'(v));
      rd(ADDR_INPUT_PORT_LEVEL, v);
      chk("input level", 12'(in_pin), 12'(v));
    end
    wr(ADDR_SHARED_PORT_CONTROL, 4'h1);
    chk("input pulls high-z", 12'h000, {4'h0, ipd, ipu});
    $display("test output and input ports done");
    for (int i = 0; i < 4; i++)
    begin
      dir = (i == 0) ? 4'h0 : 4'($urandom);
      d = 4'($urandom);
      pins = 4'($urandom);
      for (int b = 0; b < 4; b++)
        wr(ADDR_BIT_CONTROL_BASE + 8'(4 + b), {2'b00, dir[b], i[0]});
      ext_en = {4'h0, ~dir, 4'h0};
      ext_val = {4'h0, pins, 4'h0};
      wr(ADDR_THIRD_PORT_DATA, d);
      step(2);
      rd(ADDR_THIRD_PORT_DATA, v);
      chk("third port", 12'((d & dir) | (pins & ~dir)), 12'(v));
      chk("third pads", 12'(d & dir), 12'((bpin_o[7:4] | ~bpin_oe[7:4]) & dir));
    end
    $display("test third port done");
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_SHARED_PORT_CONTROL, {1'b0, i[1], 2'b00});
      chk("input pulls", i[1] ? 12'h0f0 : 12'h00f, {4'h0, ipd, ipu});
      in_pin = lvl_a[i];
      step(3);
      tick();
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      in_pin = lvl_b[i];
      step(3);
      chk("flag before tick", 12'h000, 12'(flag));
      tick();
      chk("flag", 12'(fires(i[1], lvl_a[i], lvl_b[i])), 12'(flag));
      rd(ADDR_INPUT_PORT_LEVEL, v);
      chk("input after flag", 12'(lvl_b[i]), 12'(v));
    end
    $display("test level change done");
    ext_en = 12'h010;
    ext_val = 12'h000;
    wr(ADDR_BIT_CONTROL_BASE + 8'h04, 4'hc);
    step(4);
    bclr = 1'b1;
    step(1);
    bclr = 1'b0;
    chk("bidir flag idle", 12'h000, 12'(bflag));
    ext_val = 12'h010;
    step(4);
    chk("bidir flag", 12'h001, 12'(bflag));
    $display("test bidirectional change done");
    wrap_up();
  end
endmodule : four_bit_io_ports_test
